// *** hdl/pfbc_regs.svh ***
// Constants for the parallel flash bus controller.
`ifndef PFBC_REGS_SVH
`define PFBC_REGS_SVH
`define PFBC_CLK_NS        50
`define PFBC_RESET_LOW_NS  500
`define PFBC_RESET_CYC     ((`PFBC_RESET_LOW_NS + `PFBC_CLK_NS - 1) / `PFBC_CLK_NS)
`define PFBC_RB_SYNC_CYC   2
`define PFBC_RECOVERY_NS   20000
`define PFBC_RECOVERY_CYC  ((`PFBC_RECOVERY_NS + `PFBC_CLK_NS - 1) / `PFBC_CLK_NS)
`define PFBC_GLITCH_NS     5
`define PFBC_STROBE_NS     100
`define PFBC_STROBE_CYC    ((`PFBC_STROBE_NS + `PFBC_CLK_NS - 1) / `PFBC_CLK_NS)
`define PFBC_CNT_W         16
`define PFBC_ID_A1_BIT     1
`define PFBC_ID_A0_BIT     0
`define PFBC_SA_LSB        16
`endif

// *** hdl/pfbc_pkg.sv ***
// Types for the parallel flash bus controller.
package pfbc_pkg;
  typedef enum logic [1:0] {
    PFBC_OP_READ,
    PFBC_OP_WRITE,
    PFBC_OP_LOCK,
    PFBC_OP_MFR
  } pfbc_op_t;
  typedef enum logic [2:0] {
    PFBC_RESET,
    PFBC_RECOVER,
    PFBC_IDLE,
    PFBC_SETUP,
    PFBC_STROBE,
    PFBC_HOLD
  } pfbc_state_t;
endpackage : pfbc_pkg

// *** hdl/pfbc_host.sv ***
// Host controller driving the bus of an asynchronous parallel NOR flash.
`include "pfbc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module pfbc_host #(
  parameter int ADDR_W       = 26,
  parameter int RESET_CYC    = `PFBC_RESET_CYC,
  parameter int RECOVERY_CYC = `PFBC_RECOVERY_CYC,
  parameter int STROBE_CYC   = `PFBC_STROBE_CYC
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_N_I,
  input  wire logic              CE_I,
  input  wire logic              REQ_I,
  input  wire logic [1:0]        OP_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [15:0]       WDATA_I,
  input  wire logic              WORD_MODE_I,
  input  wire logic              PROTECT_I,
  input  wire logic              ACCEL_I,
  input  wire logic              FLASH_RESET_I,
  output logic                   BUSY_O,
  output logic                   DONE_O,
  output logic [15:0]            RDATA_O,
  output logic                   FLASH_BUSY_O,
  output logic                   F_RESET_N_O,
  output logic                   F_CE_N_O,
  output logic                   F_WE_N_O,
  output logic                   F_OE_N_O,
  output logic                   F_WIDTH_SEL_O,
  output logic                   F_PROTECT_N_O,
  output logic                   F_ACCEL_HV_O,
  output logic                   F_ID_HV_O,
  output logic [ADDR_W-1:0]      F_ADDR_O,
  output logic [15:0]            F_DQ_O,
  output logic [15:0]            F_DQ_OE_N_O,
  input  wire logic [15:0]       F_DQ_I,
  input  wire logic              F_READY_BUSY_I
);
  typedef logic [`PFBC_CNT_W-1:0] pfbc_cnt_t;

  pfbc_pkg::pfbc_state_t state, next_state;
  pfbc_pkg::pfbc_op_t    op, next_op;
  pfbc_cnt_t             cnt, next_cnt;
  logic                  busy, next_busy;
  logic                  done, next_done;
  logic [15:0]           rdata, next_rdata;
  logic                  rst_n, next_rst_n;
  logic                  ce_n, next_ce_n;
  logic                  we_n, next_we_n;
  logic                  oe_n, next_oe_n;
  logic                  hv, next_hv;
  logic [ADDR_W-1:0]     addr, next_addr;
  logic [15:0]           dq, next_dq;
  logic [15:0]           dq_oe_n, next_dq_oe_n;
  logic                  wide, next_wide;
  logic [2:0]            rb_sync;
  logic                  rb_stable;
  logic                  flash_busy;

  // Ready/busy pin is asynchronous; it counts once stages two and three agree.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rb_sync    <= 3'h7;
      rb_stable  <= 1'b1;
    end else if (CE_I) begin
      rb_sync    <= {rb_sync[1:0], F_READY_BUSY_I};
      rb_stable  <= (rb_sync[1] == rb_sync[2]) ? rb_sync[2] : rb_stable;
    end
  end
  assign flash_busy = !rb_stable;

  // Sixteen data lanes enabled in word mode, only the low byte in byte mode.
  function automatic logic [15:0] lane_oe_n(input logic word);
    lane_oe_n = word ? 16'h0000 : 16'hff00;
  endfunction

  always_comb begin
    next_state   = state;
    next_op      = op;
    next_cnt     = (cnt != '0) ? cnt - pfbc_cnt_t'(1) : cnt;
    next_busy    = busy;
    next_done    = 1'b0;
    next_rdata   = rdata;
    next_rst_n   = rst_n;
    next_ce_n    = ce_n;
    next_we_n    = we_n;
    next_oe_n    = oe_n;
    next_hv      = hv;
    next_addr    = addr;
    next_dq      = dq;
    next_dq_oe_n = dq_oe_n;
    next_wide    = wide;
    case (state)
      pfbc_pkg::PFBC_RESET: begin
        if (cnt == '0) begin
          next_rst_n = 1'b1;
          next_cnt   = pfbc_cnt_t'(RECOVERY_CYC);
          next_state = pfbc_pkg::PFBC_RECOVER;
        end
      end
      pfbc_pkg::PFBC_RECOVER: begin
        // Recovery ends early once the device reports ready, else at the time bound.
        if (cnt == '0 || (!flash_busy && cnt < pfbc_cnt_t'(RECOVERY_CYC - `PFBC_RB_SYNC_CYC))) begin
          next_busy  = 1'b0;
          next_state = pfbc_pkg::PFBC_IDLE;
        end
      end
      pfbc_pkg::PFBC_IDLE: begin
        if (FLASH_RESET_I) begin
          next_rst_n = 1'b0;
          next_busy  = 1'b1;
          next_ce_n  = 1'b1;
          next_cnt   = pfbc_cnt_t'(RESET_CYC);
          next_state = pfbc_pkg::PFBC_RESET;
        end else if (REQ_I && !(flash_busy && OP_I != 2'(pfbc_pkg::PFBC_OP_WRITE))) begin
          next_op      = pfbc_pkg::pfbc_op_t'(OP_I);
          next_busy    = 1'b1;
          next_wide    = WORD_MODE_I;
          next_addr    = ADDR_I;
          next_hv      = (OP_I == 2'(pfbc_pkg::PFBC_OP_LOCK)) || (OP_I == 2'(pfbc_pkg::PFBC_OP_MFR));
          if (OP_I == 2'(pfbc_pkg::PFBC_OP_LOCK)) begin
            next_addr[`PFBC_ID_A1_BIT] = 1'b1;
            next_addr[`PFBC_ID_A0_BIT] = 1'b0;
          end
          if (!WORD_MODE_I) begin
            next_dq[15] = ADDR_I[0];
          end
          next_ce_n  = 1'b0;
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_dq_oe_n = WORD_MODE_I ? 16'hffff : 16'h7fff;
          next_cnt   = pfbc_cnt_t'(STROBE_CYC);
          next_state = pfbc_pkg::PFBC_SETUP;
        end else begin
          next_ce_n    = 1'b1;
          next_dq_oe_n = 16'hffff;
        end
      end
      pfbc_pkg::PFBC_SETUP: begin
        if (cnt == '0) begin
          if (op == pfbc_pkg::PFBC_OP_WRITE) begin
            // Output enable is held high through the write strobe.
            next_we_n    = 1'b0;
            next_dq      = wide ? WDATA_I : {addr[0], 7'h00, WDATA_I[7:0]};
            next_dq_oe_n = wide ? lane_oe_n(1'b1) : 16'h7f00;
          end else begin
            next_oe_n = 1'b0;
          end
          // Strobe width of STROBE_CYC + 1 cycles is far above the glitch floor.
          next_cnt   = pfbc_cnt_t'(STROBE_CYC);
          next_state = pfbc_pkg::PFBC_STROBE;
        end
      end
      pfbc_pkg::PFBC_STROBE: begin
        if (cnt == '0) begin
          if (op != pfbc_pkg::PFBC_OP_WRITE) begin
            next_rdata = wide ? F_DQ_I : {8'h00, F_DQ_I[7:0]};
            if (op == pfbc_pkg::PFBC_OP_LOCK) begin
              next_rdata = {15'h0000, F_DQ_I[0]};
            end
          end
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_cnt   = pfbc_cnt_t'(STROBE_CYC);
          next_state = pfbc_pkg::PFBC_HOLD;
        end
      end
      pfbc_pkg::PFBC_HOLD: begin
        if (cnt == '0) begin
          next_ce_n    = 1'b1;
          next_hv      = 1'b0;
          next_dq_oe_n = 16'hffff;
          next_busy    = 1'b0;
          next_done    = 1'b1;
          next_state   = pfbc_pkg::PFBC_IDLE;
        end
      end
      default: begin
        next_state = pfbc_pkg::PFBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      // Flash reset starts asserted so the device comes up in read mode.
      state   <= pfbc_pkg::PFBC_RESET;
      op      <= pfbc_pkg::PFBC_OP_READ;
      cnt     <= pfbc_cnt_t'(RESET_CYC);
      busy    <= 1'b1;
      done    <= 1'b0;
      rdata   <= 16'h0000;
      rst_n   <= 1'b0;
      ce_n    <= 1'b1;
      we_n    <= 1'b1;
      oe_n    <= 1'b1;
      hv      <= 1'b0;
      addr    <= '0;
      dq      <= 16'h0000;
      dq_oe_n <= 16'hffff;
      wide    <= 1'b1;
    end else if (CE_I) begin
      state   <= next_state;
      op      <= next_op;
      cnt     <= next_cnt;
      busy    <= next_busy;
      done    <= next_done;
      rdata   <= next_rdata;
      rst_n   <= next_rst_n;
      ce_n    <= next_ce_n;
      we_n    <= next_we_n;
      oe_n    <= next_oe_n;
      hv      <= next_hv;
      addr    <= next_addr;
      dq      <= next_dq;
      dq_oe_n <= next_dq_oe_n;
      wide    <= next_wide;
    end
  end

  logic prot_n, accel, fbusy_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      prot_n  <= 1'b0;
      accel   <= 1'b0;
      fbusy_q <= 1'b0;
    end else if (CE_I) begin
      prot_n  <= !PROTECT_I;
      accel   <= ACCEL_I;
      fbusy_q <= flash_busy;
    end
  end

  // Counts the cycles the flash reset has been held low, for the minimum-width check.
  pfbc_cnt_t             rst_low, next_rst_low;
  always_comb begin
    next_rst_low = rst_low;
    if (rst_n) begin
      next_rst_low = '0;
    end else if (rst_low != '1) begin
      next_rst_low = rst_low + pfbc_cnt_t'(1);
    end
  end
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rst_low <= '0;
    end else if (CE_I) begin
      rst_low <= next_rst_low;
    end
  end

  assign BUSY_O        = busy;
  assign DONE_O        = done;
  assign RDATA_O       = rdata;
  assign FLASH_BUSY_O  = fbusy_q;
  assign F_RESET_N_O   = rst_n;
  assign F_CE_N_O      = ce_n;
  assign F_WE_N_O      = we_n;
  assign F_OE_N_O      = oe_n;
  assign F_WIDTH_SEL_O = wide;
  assign F_PROTECT_N_O = prot_n;
  assign F_ACCEL_HV_O  = accel;
  assign F_ID_HV_O     = hv;
  assign F_ADDR_O      = addr;
  assign F_DQ_O        = dq;
  assign F_DQ_OE_N_O   = dq_oe_n;

  sequence write_strobe_s;
    !we_n && !ce_n && oe_n;
  endsequence

  write_inhibit_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !we_n |-> (!ce_n && oe_n)) else $error("write strobe without select or with output enable");
  no_we_oe_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !oe_n |-> we_n) else $error("read with write strobe low");
  strobe_width_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I || !CE_I)
    $fell(we_n) |-> !we_n [*2]) else $error("write strobe too short");
  reset_width_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I || !CE_I)
    $rose(rst_n) |-> rst_low >= pfbc_cnt_t'(RESET_CYC)) else $error("flash reset released too early");
  data_lanes_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    (!wide && !ce_n) |-> (dq_oe_n[14:8] == 7'h7f)) else $error("high lanes driven in byte mode");
  write_data_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I || !CE_I)
    write_strobe_s ##1 $rose(we_n) |-> $past(dq_oe_n[0]) == 1'b0) else $error("data not driven at strobe rise");
  read_float_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    !oe_n |-> (dq_oe_n == 16'hffff || dq_oe_n == 16'h7fff)) else $error("bus contention during read");
  standby_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    ce_n |-> (we_n && oe_n)) else $error("strobe active while deselected");
endmodule : pfbc_host
`default_nettype wire

// *** bench/pfbc_flash_model.sv ***
// Behavioural flash device answering the host controller's bus.
`timescale 1ns/10ps
`default_nettype none
module pfbc_flash_model #(
  parameter logic [7:0] MFR_CODE    = 8'h5a, // Arbitrary identification value.
  parameter logic       FACT_LOCKED = 1'b1,
  parameter int         BUSY_CYC    = 6
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        width_sel_i,
  input  wire logic        protect_n_i,
  input  wire logic        id_hv_i,
  input  wire logic [25:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic             ready_busy_o
);
  logic [15:0] mem [0:15];
  logic [25:0] lat_a;
  logic        lat_b;
  logic [15:0] rd;
  logic [15:0] en;
  logic [15:0] last;
  int          busy;
  realtime     t_fall;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    busy = 0;
    last = 16'h0000;
  end
  always @(negedge we_n_i) begin
    t_fall = $realtime;
    lat_a  = addr_i;
    lat_b  = dq_i[15];
  end
  // Programming only clears bits, so a stored 0 survives any later write.
  always @(posedge we_n_i) begin
    if (!ce_n_i && oe_n_i && reset_n_i && busy == 0 && $realtime - t_fall >= 5.0
        && !(!protect_n_i && lat_a[25:16] == 10'h000)) begin
      if (width_sel_i) mem[lat_a[3:0]] = mem[lat_a[3:0]] & dq_i;
      else if (lat_b) mem[lat_a[3:0]][15:8] = mem[lat_a[3:0]][15:8] & dq_i[7:0];
      else mem[lat_a[3:0]][7:0] = mem[lat_a[3:0]][7:0] & dq_i[7:0];
      busy = BUSY_CYC;
    end
  end
  always @(posedge clk_i) begin
    last <= dq_o;
    if (!reset_n_i) begin
      if (busy != 0) busy <= BUSY_CYC;
    end else if (busy != 0) busy <= busy - 1;
  end
  assign ready_busy_o = (busy == 0);
  always @* begin
    rd = mem[addr_i[3:0]];
    if (id_hv_i && busy == 0 && !addr_i[6] && addr_i[3:2] == 2'b00) begin
      case (addr_i[1:0])
        2'b10: rd = {15'h0000, !protect_n_i && addr_i[25:16] == 10'h000};
        2'b00: rd = {8'h00, MFR_CODE};
        2'b11: rd = FACT_LOCKED ? 16'h0089 : 16'h0009;
        default: rd = 16'h0000;
      endcase
    end
    if (!width_sel_i) rd = {8'h00, dq_i[15] ? rd[15:8] : rd[7:0]};
    en = (width_sel_i ? 16'hffff : 16'h00ff) & {16{reset_n_i && !ce_n_i && !oe_n_i && we_n_i}};
    dq_o = (rd & en) | (~last & ~en);
  end
endmodule : pfbc_flash_model
`default_nettype wire

// *** bench/pfbc_host_tb.sv ***
// Self-checking bench for the parallel flash bus controller.
`timescale 1ns/10ps
`default_nettype none
module pfbc_host_tb;
  typedef struct {logic chk; logic [15:0] v; logic [15:0] m; logic a;} pfbc_note_t;
  localparam int T_RST = 2;
  logic clk, rst_n, req, word_mode, protect, accel, flash_reset;
  logic [1:0]  op;
  logic [25:0] addr, f_addr;
  logic [15:0] wdata, rdata, f_dq, f_dq_oe_n, m_dq, dq_wire;
  logic busy_o, done_o, fbusy, f_rst_n, f_ce_n, f_we_n, f_oe_n, f_wsel, f_prot_n, f_acc, f_id, f_rb;
  logic [15:0] shadow [0:15];
  pfbc_note_t  q [$];
  pfbc_note_t  nt;
  int n_fail, tests_run, seed, cnt;
  logic [15:0] d;
  logic [3:0]  ix;
  assign dq_wire = (f_dq & ~f_dq_oe_n) | (m_dq & f_dq_oe_n);
  pfbc_host #(.ADDR_W(26), .RESET_CYC(T_RST), .RECOVERY_CYC(5), .STROBE_CYC(2)) DUT (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .REQ_I(req), .OP_I(op), .ADDR_I(addr),
    .WDATA_I(wdata), .WORD_MODE_I(word_mode), .PROTECT_I(protect), .ACCEL_I(accel),
    .FLASH_RESET_I(flash_reset), .BUSY_O(busy_o), .DONE_O(done_o), .RDATA_O(rdata),
    .FLASH_BUSY_O(fbusy), .F_RESET_N_O(f_rst_n), .F_CE_N_O(f_ce_n), .F_WE_N_O(f_we_n),
    .F_OE_N_O(f_oe_n), .F_WIDTH_SEL_O(f_wsel), .F_PROTECT_N_O(f_prot_n), .F_ACCEL_HV_O(f_acc),
    .F_ID_HV_O(f_id), .F_ADDR_O(f_addr), .F_DQ_O(f_dq), .F_DQ_OE_N_O(f_dq_oe_n),
    .F_DQ_I(dq_wire), .F_READY_BUSY_I(f_rb));
  pfbc_flash_model MODEL (
    .clk_i(clk), .reset_n_i(f_rst_n), .ce_n_i(f_ce_n), .we_n_i(f_we_n), .oe_n_i(f_oe_n),
    .width_sel_i(f_wsel), .protect_n_i(f_prot_n), .id_hv_i(f_id), .addr_i(f_addr),
    .dq_i(dq_wire), .dq_o(m_dq), .ready_busy_o(f_rb));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Waits for both the controller and the flash to be idle, since id reads are refused while busy.
  task automatic xfer(input logic [1:0] o, input logic [25:0] a, input logic [15:0] dd,
                      input logic c, input logic [15:0] e, input logic [15:0] m);
    int g;
    logic acc;
    g = 0;
    acc = 1'($random(seed));
    repeat (8) @(posedge clk);
    while ((fbusy !== 1'b0 || busy_o !== 1'b0) && g < 500) begin
      @(posedge clk);
      g++;
    end
    q.push_back('{c, e, m, acc});
    op    <= o;
    addr  <= a;
    wdata <= dd;
    accel <= acc;
    req   <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    g = 0;
    @(negedge clk);
    while (done_o !== 1'b1 && g < 500) begin
      @(negedge clk);
      g++;
    end
    if (g >= 500) n_fail++;
    @(posedge clk);
  endtask : xfer
  always @(negedge clk) begin
    if (done_o === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      if (nt.chk) check("RDATA_O", rdata & nt.m, nt.v);
      check("F_ACCEL_HV_O", {15'h0000, f_acc}, {15'h0000, nt.a});
      check("BUSY_O", {15'h0000, busy_o}, 16'h0000);
    end
  end
  task automatic summarize();
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    #1000000;
    n_fail++;
    summarize();
  end
  initial begin
    seed = 4351;
    n_fail = 0;
    tests_run = 0;
    rst_n = 1'b0; req = 1'b0; op = 2'd0; addr = 26'h0; wdata = 16'h0;
    word_mode = 1'b0; protect = 1'b0; accel = 1'b0; flash_reset = 1'b0;
    for (int i = 0; i < 16; i++) shadow[i] = 16'hffff;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    d = 16'($random(seed));
    xfer(2'd1, 26'h0010002, d, 1'b0, 16'h0, 16'h0);
    xfer(2'd1, 26'h0010003, ~d, 1'b0, 16'h0, 16'h0);
    xfer(2'd0, 26'h0010002, 16'h0, 1'b1, {8'h00, d[7:0]}, 16'h00ff);
    xfer(2'd0, 26'h0010003, 16'h0, 1'b1, {8'h00, ~d[7:0]}, 16'h00ff);
    word_mode <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      ix = {1'b1, 3'($random(seed))};
      d  = 16'($random(seed));
      shadow[ix] = shadow[ix] & d;
      xfer(2'd1, {22'h001000, ix}, d, 1'b0, 16'h0, 16'h0);
      xfer(2'd0, {22'h001000, ix}, 16'h0, 1'b1, shadow[ix], 16'hffff);
    end
    protect <= 1'b1;
    xfer(2'd1, 26'h0000005, 16'h0000, 1'b0, 16'h0, 16'h0);
    xfer(2'd0, 26'h0000005, 16'h0, 1'b1, 16'hffff, 16'hffff);
    xfer(2'd2, 26'h000ff30, 16'h0, 1'b1, 16'h0001, 16'h0001);
    xfer(2'd2, 26'h0010030, 16'h0, 1'b1, 16'h0000, 16'h0001);
    xfer(2'd3, 26'h0000000, 16'h0, 1'b1, 16'h005a, 16'h00ff);
    xfer(2'd3, 26'h0000003, 16'h0, 1'b1, 16'h0089, 16'h00ff);
    protect <= 1'b0;
    xfer(2'd2, 26'h000ff30, 16'h0, 1'b1, 16'h0000, 16'h0001);
    d = 16'($random(seed));
    shadow[15] = shadow[15] & d;
    xfer(2'd1, 26'h001000f, d, 1'b0, 16'h0, 16'h0);
    flash_reset <= 1'b1;
    @(posedge clk);
    flash_reset <= 1'b0;
    cnt = 0;
    for (int g = 0; g < 20 && f_rst_n !== 1'b0; g++) @(negedge clk);
    while (f_rst_n === 1'b0 && cnt < 50) begin
      @(negedge clk);
      cnt++;
    end
    check("reset_low_cycles", 16'(cnt), 16'(T_RST + 1));
    xfer(2'd0, 26'h001000f, 16'h0, 1'b1, shadow[15], 16'hffff);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule : pfbc_host_tb
`default_nettype wire
